/* core/smp_pkg.sv */
/*
  shared constants for the step motion profile generator: register map,
  field positions, reset values, timing and rate figures.
  assumes a 100 MHz clock and a 32-bit AXI4-Lite register bus.
*/
package smp_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MASTER_CONFIG_REG = 8'h00;  // master_config_reg
  localparam logic [7:0] OFS_INPUT_CONFIG_REG = 8'h04;  // input_config_reg
  localparam logic [7:0] OFS_SPEED = 8'h08;  // speed_cmd, signed 16 bit
  localparam logic [7:0] OFS_DISP = 8'h0C;  // displacement_cmd, signed 32 bit
  localparam logic [7:0] OFS_ACCEL = 8'h10;  // accel_rate_cmd
  localparam logic [7:0] OFS_DECEL = 8'h14;  // decel_rate_cmd
  localparam logic [7:0] OFS_MSS = 8'h18;  // max_start_speed_cmd, pps
  localparam logic [7:0] OFS_MSD = 8'h1C;  // max_stop_speed_cmd, pps
  localparam logic [7:0] OFS_BLC = 8'h20;  // backlash_comp_cmd, pulses
  localparam logic [7:0] OFS_POS = 8'h24;  // absolute position, write clears
  localparam logic [7:0] OFS_DCNT = 8'h28;  // displacement counter
  localparam logic [7:0] OFS_STAT = 8'h2C;  // status_query

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_EN = 10;  // profile_enable_bit
  localparam int BIT_AM = 11;  // accel_mode_select
  localparam int BIT_DM = 12;  // decel_mode_select
  localparam int BIT_SENSE = 0;  // count_sense_bit
  localparam logic [31:0] RST_WORD = 32'h0000_0000;  // every register below the status word resets to zero
  localparam logic [31:0] BLC_MAX = 32'h0001_0000;  // largest backlash count

  // ----------------------------------------------------------------
  // timing and rates
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;  // 100 MHz
  localparam int TICK_TIME_US = 1000;  // profile update interval
  localparam int TICK_CYC = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam logic [31:0] MPPS_PER_PPS = 32'h0000_03E8;  // speeds held in milli-pps
  localparam logic [39:0] STEP_WRAP = 40'(64'd1_000_000_000 / CLK_PERIOD_NS * 64'd1000);
  localparam logic [31:0] BL_MPPS = 32'h000F_4240;  // backlash pulses at 1000 pps
  localparam logic [31:0] CREEP_MPPS = 32'h0001_86A0;  // 100 pps floor near the end
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // complete state of the generator
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] master_config_reg;
    logic [31:0] input_config_reg;
    logic [31:0] speed_cmd;
    logic [31:0] disp;
    logic [31:0] acc;
    logic [31:0] dec;
    logic [31:0] mss;
    logic [31:0] msd;
    logic [31:0] backlash_comp_cmd;
    logic [31:0] acc_step;
    logic [31:0] dec_step;
    logic [31:0] cur;
    logic dir;
    logic moved;
    logic [16:0] bl_cnt;
    logic disp_mode;
    logic [31:0] rem;
    logic [31:0] pos;
    logic [31:0] dcnt;
    logic [39:0] ph;
    logic [31:0] tcnt;
    logic step;
    logic nv_req;
    logic [7:0] nv_addr;
    logic [31:0] nv_data;
  } smp_state_t;

endpackage

/* core/smp_profile_gen.sv */
/*
  step motion profile generator: ramps the step rate toward the commanded
  speed, schedules deceleration for displacement moves, arbitrates the
  motor direction, counts position and inserts backlash pulses.
  assumes an AXI4-Lite master on the register side, a power stage that
  takes one step per step_out pulse, and an external backup store.
*/
`timescale 1ns/1ps

module smp_profile_gen #(
  parameter int TICK_CYC = smp_pkg::TICK_CYC  // cycles per profile update
) (
  input wire logic aclk,  // 100 MHz clock
  input wire logic aresetn,  // synchronous reset, active low
  input wire logic [7:0] awaddr,  // write address
  input wire logic awvalid,  // write address valid
  output logic awready,  // write address ready
  input wire logic [31:0] wdata,  // write data
  input wire logic [3:0] wstrb,  // write byte strobes
  input wire logic wvalid,  // write data valid
  output logic wready,  // write data ready
  output logic [1:0] bresp,  // write response
  output logic bvalid,  // write response valid
  input wire logic bready,  // write response ready
  input wire logic [7:0] araddr,  // read address
  input wire logic arvalid,  // read address valid
  output logic arready,  // read address ready
  output logic [31:0] rdata,  // read data
  output logic [1:0] rresp,  // read response
  output logic rvalid,  // read data valid
  input wire logic rready,  // read data ready
  input wire logic pos_clear_evt,  // sensor event clearing position
  input wire logic pos_restore,  // reload position after power-up
  input wire logic [31:0] pos_restore_val,  // saved position value
  output logic [31:0] pos_backup,  // position for the backup store
  output logic step_out,  // one-cycle step pulse
  output logic dir_out,  // actual direction, 1 forward
  output logic nv_req,  // one-cycle parameter save request
  output logic [7:0] nv_addr,  // offset of parameter being saved
  output logic [31:0] nv_data  // value being saved
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // merge a bus write into a register under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // ramp increment in mpps per tick: rate directly, or span spread over a time
  function automatic logic [31:0] ramp_step(input logic per, input logic [31:0] cmd,
                                            input logic [31:0] span);
    logic [31:0] c;
    logic [31:0] s;
    c = (cmd == 32'h0000_0000) ? 32'h0000_0001 : cmd;
    s = per ? span / c : c;
    return (s == 32'h0000_0000) ? 32'h0000_0001 : s;
  endfunction

  smp_pkg::smp_state_t r;  // registered state
  smp_pkg::smp_state_t n;  // next state
  logic wr_do;  // write handshake this edge
  logic rd_do;  // read handshake this edge
  logic tick;  // profile update enable
  logic en;  // profile block enabled
  logic ddir;  // commanded direction
  logic [31:0] tmag;  // commanded speed magnitude, mpps
  logic [31:0] tgt;  // effective ramp target, mpps
  logic [31:0] mss_m;  // start speed threshold, mpps
  logic [31:0] msd_m;  // stop speed threshold, mpps
  logic cnt_step;  // step that moves the load
  logic pos_clr;  // any position clear or reload

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [15:0] s16;
    logic [31:0] wv;
    logic [31:0] pps;
    logic [39:0] ph_sum;
    logic [31:0] rate;
    logic recalc;
    logic need_dec;
    s16 = '0;
    wv = '0;
    pps = '0;
    ph_sum = '0;
    rate = '0;
    recalc = 1'b0;
    need_dec = 1'b0;
    n = r;
    n.step = 1'b0;
    n.nv_req = 1'b0;
    wr_do = r.awready && awvalid && wvalid;
    rd_do = r.arready && arvalid;
    tick = (r.tcnt == 32'(TICK_CYC - 1));
    n.tcnt = tick ? 32'h0000_0000 : r.tcnt + 32'h0000_0001;
    en = r.master_config_reg[smp_pkg::BIT_EN];
    mss_m = 32'(r.mss[15:0]) * smp_pkg::MPPS_PER_PPS;
    msd_m = 32'(r.msd[15:0]) * smp_pkg::MPPS_PER_PPS;

    // write channel: ready raised once both halves wait, answer after take
    n.awready = 1'b0;
    n.wready = 1'b0;
    if (awvalid && wvalid && !r.awready && !r.bvalid)
    begin
      n.awready = 1'b1;
      n.wready = 1'b1;
    end
    if (r.bvalid && bready)
    begin
      n.bvalid = 1'b0;
    end
    pos_clr = pos_clear_evt || pos_restore;
    if (wr_do)
    begin
      n.bvalid = 1'b1;
      n.bresp = smp_pkg::RESP_OK;
      n.nv_addr = awaddr;
      unique case (awaddr)
        smp_pkg::OFS_MASTER_CONFIG_REG:
        begin
          wv = merge(r.master_config_reg, wdata, wstrb);
          n.master_config_reg = wv;
        end
        smp_pkg::OFS_INPUT_CONFIG_REG:
        begin
          wv = merge(r.input_config_reg, wdata, wstrb);
          n.input_config_reg = wv;
        end
        smp_pkg::OFS_SPEED:
        begin
          wv = merge(r.speed_cmd, wdata, wstrb);
          n.speed_cmd = wv;
        end
        smp_pkg::OFS_DISP:
        begin
          wv = merge(r.disp, wdata, wstrb);
          n.disp = wv;
          n.dcnt = 32'h0000_0000;
          n.disp_mode = (wv != 32'h0000_0000);
          n.rem = wv[31] ? 32'h0000_0000 - wv : wv;
        end
        smp_pkg::OFS_ACCEL:
        begin
          wv = merge(r.acc, wdata, wstrb);
          n.acc = wv;
        end
        smp_pkg::OFS_DECEL:
        begin
          wv = merge(r.dec, wdata, wstrb);
          n.dec = wv;
        end
        smp_pkg::OFS_MSS:
        begin
          wv = merge(r.mss, wdata, wstrb);
          n.mss = wv;
        end
        smp_pkg::OFS_MSD:
        begin
          wv = merge(r.msd, wdata, wstrb);
          n.msd = wv;
        end
        smp_pkg::OFS_BLC:
        begin
          wv = merge(r.backlash_comp_cmd, wdata, wstrb);
          n.backlash_comp_cmd = (wv > smp_pkg::BLC_MAX) ? smp_pkg::BLC_MAX : wv;
        end
        smp_pkg::OFS_POS:
        begin
          pos_clr = 1'b1;
        end
        smp_pkg::OFS_DCNT, smp_pkg::OFS_STAT:
        begin
          n.bresp = smp_pkg::RESP_OK;  // read-only, write ignored
        end
        default:
        begin
          n.bresp = smp_pkg::RESP_SLVERR;
        end
      endcase
      // parameter saves run beside the profile and never hold it up
      if (awaddr <= smp_pkg::OFS_BLC && awaddr[1:0] == 2'h0)
      begin
        n.nv_req = 1'b1;
        n.nv_data = wv;
      end
      recalc = 1'b1;
    end

    // read channel
    n.arready = 1'b0;
    if (arvalid && !r.arready && !r.rvalid)
    begin
      n.arready = 1'b1;
    end
    if (r.rvalid && rready)
    begin
      n.rvalid = 1'b0;
    end
    if (rd_do)
    begin
      n.rvalid = 1'b1;
      n.rresp = smp_pkg::RESP_OK;
      pps = r.cur / smp_pkg::MPPS_PER_PPS;
      unique case (araddr)
        smp_pkg::OFS_MASTER_CONFIG_REG: n.rdata = r.master_config_reg;
        smp_pkg::OFS_INPUT_CONFIG_REG: n.rdata = r.input_config_reg;
        smp_pkg::OFS_SPEED: n.rdata = r.speed_cmd;
        smp_pkg::OFS_DISP: n.rdata = r.disp;
        smp_pkg::OFS_ACCEL: n.rdata = r.acc;
        smp_pkg::OFS_DECEL: n.rdata = r.dec;
        smp_pkg::OFS_MSS: n.rdata = r.mss;
        smp_pkg::OFS_MSD: n.rdata = r.msd;
        smp_pkg::OFS_BLC: n.rdata = r.backlash_comp_cmd;
        smp_pkg::OFS_POS: n.rdata = r.pos;
        smp_pkg::OFS_DCNT: n.rdata = r.dcnt;
        smp_pkg::OFS_STAT: n.rdata = {pps[15:0], 13'h0000, r.bl_cnt != 17'h00000,
                                      r.disp_mode, r.dir};
        default:
        begin
          n.rdata = 32'h0000_0000;
          n.rresp = smp_pkg::RESP_SLVERR;
        end
      endcase
    end

    // commanded direction and speed
    s16 = r.speed_cmd[15] ? 16'h0000 - r.speed_cmd[15:0] : r.speed_cmd[15:0];
    ddir = r.disp_mode ? !r.disp[31] : !r.speed_cmd[15];
    tmag = 32'(s16) * smp_pkg::MPPS_PER_PPS;
    if (r.disp_mode && r.rem == 32'h0000_0000)
    begin
      tmag = 32'h0000_0000;
    end
    // stopping distance against remaining travel, 64-bit products
    pps = r.cur / smp_pkg::MPPS_PER_PPS;
    need_dec = r.disp_mode && (64'(r.rem) * 64'(r.dec_step) * 64'h2 <=
                               64'(pps) * 64'(pps));
    // a reversal first brings the motor to rest
    tgt = (ddir != r.dir || need_dec) ? 32'h0000_0000 : tmag;

    // ramp increments follow the mode bits, latched on any write
    if (recalc)
    begin
      wv = (n.speed_cmd[15] ? 16'h0000 - n.speed_cmd[15:0] : n.speed_cmd[15:0]) * 32'h0000_0001;
      wv = wv * smp_pkg::MPPS_PER_PPS;
      wv = (wv > r.cur) ? wv - r.cur : r.cur - wv;
      n.acc_step = ramp_step(n.master_config_reg[smp_pkg::BIT_AM], n.acc, wv);
      n.dec_step = ramp_step(n.master_config_reg[smp_pkg::BIT_DM], n.dec,
                             (wv == 32'h0000_0000) ? r.cur : wv);
    end

    if (!en)
    begin
      // without the profile the speed and direction follow at once
      n.cur = tmag;
      n.dir = ddir;
    end
    else
    begin
      // direction changes only from rest, with backlash taken up first
      if (r.cur == 32'h0000_0000 && ddir != r.dir && tmag != 32'h0000_0000 &&
          r.bl_cnt == 17'h00000)
      begin
        n.dir = ddir;
        if (r.moved && r.backlash_comp_cmd != 32'h0000_0000)
        begin
          n.bl_cnt = r.backlash_comp_cmd[16:0];
        end
      end
      if (tick && r.bl_cnt == 17'h00000)
      begin
        if (r.cur < tgt)
        begin
          if (r.mss != 32'h0000_0000 && tgt <= mss_m)
          begin
            n.cur = tgt;
          end
          else if (r.mss != 32'h0000_0000 && r.cur < mss_m)
          begin
            n.cur = mss_m;
          end
          else
          begin
            n.cur = (tgt - r.cur > r.acc_step) ? r.cur + r.acc_step : tgt;
          end
        end
        else if (r.cur > tgt)
        begin
          if (r.msd != 32'h0000_0000 && tgt < msd_m && r.cur <= msd_m)
          begin
            n.cur = tgt;
          end
          else if (r.msd != 32'h0000_0000 && tgt < msd_m)
          begin
            // ramp to the stop threshold, the drop follows next tick
            n.cur = (r.cur - msd_m > r.dec_step) ? r.cur - r.dec_step : msd_m;
          end
          else
          begin
            n.cur = (r.cur - tgt > r.dec_step) ? r.cur - r.dec_step : tgt;
          end
        end
        // keep creeping so a displacement move does not stall short
        if (r.disp_mode && ddir == r.dir && tmag != 32'h0000_0000 &&
            n.cur < smp_pkg::CREEP_MPPS)
        begin
          n.cur = smp_pkg::CREEP_MPPS;
        end
      end
    end
    if (r.disp_mode && r.rem == 32'h0000_0000)
    begin
      n.cur = 32'h0000_0000;
    end

    // step generator: phase accumulator in milli-pps
    rate = (r.bl_cnt != 17'h00000) ? smp_pkg::BL_MPPS : r.cur;
    ph_sum = r.ph + 40'(rate);
    cnt_step = 1'b0;
    if (ph_sum >= smp_pkg::STEP_WRAP)
    begin
      n.ph = ph_sum - smp_pkg::STEP_WRAP;
      if (r.bl_cnt != 17'h00000)
      begin
        n.step = 1'b1;
        n.bl_cnt = r.bl_cnt - 17'h00001;
      end
      else if (!(r.disp_mode && r.rem == 32'h0000_0000))
      begin
        n.step = 1'b1;
        cnt_step = 1'b1;
      end
    end
    else
    begin
      n.ph = ph_sum;
    end
    if (cnt_step)
    begin
      n.moved = 1'b1;
      n.dcnt = (r.dir ? n.dcnt + 32'h0000_0001 : n.dcnt - 32'h0000_0001);
      if (r.disp_mode && r.dir == ddir)
      begin
        n.rem = n.rem - 32'h0000_0001;
      end
      n.pos = (r.dir ^ r.input_config_reg[smp_pkg::BIT_SENSE]) ? r.pos + 32'h0000_0001
                                                   : r.pos - 32'h0000_0001;
    end
    // a host write, a sensor event or the backup reload sets position, winning over a step in the same cycle
    if (pos_clr)
    begin
      n.pos = pos_restore ? pos_restore_val : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign awready = r.awready;
  assign wready = r.wready;
  assign bresp = r.bresp;
  assign bvalid = r.bvalid;
  assign arready = r.arready;
  assign rdata = r.rdata;
  assign rresp = r.rresp;
  assign rvalid = r.rvalid;
  assign pos_backup = r.pos;
  assign step_out = r.step;
  assign dir_out = r.dir;
  assign nv_req = r.nv_req;
  assign nv_addr = r.nv_addr;
  assign nv_data = r.nv_data;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_take;
    awready && awvalid && wvalid;
  endsequence

  a_dir_hold_moving: assert property (en && r.cur != 0 |=> $stable(r.dir))
    else $error("direction changed while moving");
  a_linear_rise: assert property (tick && en && r.mss == 0 && !r.disp_mode &&
    r.bl_cnt == 0 && r.cur < tgt |=> r.cur - $past(r.cur) == $past(r.acc_step) ||
    r.cur == $past(tgt))
    else $error("linear ramp step wrong");
  a_start_jump: assert property (tick && en && r.mss != 0 && !r.disp_mode &&
    r.bl_cnt == 0 && r.cur < tgt && tgt <= mss_m |=> r.cur == $past(tgt))
    else $error("start jump missed");
  a_stop_drop: assert property (tick && en && r.msd != 0 && !r.disp_mode &&
    r.bl_cnt == 0 && r.cur > tgt && tgt < msd_m && r.cur <= msd_m |=>
    r.cur == $past(tgt))
    else $error("stop drop missed");
  a_disp_end: assert property (r.disp_mode && r.rem == 0 |=> r.cur == 0 ##1 !r.step)
    else $error("motion past end of displacement");
  a_disp_clear: assert property (awready && awvalid && wvalid && awaddr == smp_pkg::OFS_DISP |=>
    r.dcnt == 0)
    else $error("displacement counter not cleared");
  a_pos_step: assert property (cnt_step && !pos_clr |=> r.step &&
    (r.pos - $past(r.pos) == 32'h1 || $past(r.pos) - r.pos == 32'h1))
    else $error("position did not follow step");
  a_bl_pos_hold: assert property (r.bl_cnt != 0 && !pos_clr |=> $stable(r.pos))
    else $error("backlash pulse moved position");
  a_write_answer: assert property (s_wr_take |=> bvalid ##1 !awready)
    else $error("write not answered");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");

endmodule

/* tb/smp_stage_model.sv */
/*
  power stage model: takes step pulses and the direction level, and keeps
  the position change that the generator should report.
  assumes one shaft step per step_out pulse, all on aclk.
*/
`timescale 1ns/1ps
module smp_stage_model (
  input wire logic aclk,  // system clock
  input wire logic step_out,  // step pulse from the generator
  input wire logic dir_out,  // 1 forward
  input wire logic sense,  // counting sense set by the host
  output int net  // expected position change
);
  // ----------------------------------------------------------------
  // step counting
  // ----------------------------------------------------------------
  initial net = 0;
  // each pulse moves one step; sign from direction and sense
  always @(posedge aclk)
  begin
    if (step_out === 1'b1)
      net <= net + ((dir_out ^ sense) ? 1 : -1);
  end
endmodule

/* tb/tb_top.sv */
/*
  testbench of the step motion profile generator: bus tasks, ramp,
  direction and position scenarios. assumes the power stage model.
*/
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic aclk = 1'b0;  // 100 MHz
  logic aresetn = 1'b0;  // active low reset
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, pos_restore_val = 32'h0, pos_backup, nv_data, v;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, step_out, dir_out, nv_req;
  logic [1:0] bresp, rresp, rs;
  logic [3:0] wstrb = 4'hF;
  logic [7:0] nv_addr;
  logic pos_clear_evt = 1'b0, pos_restore = 1'b0, sense = 1'b0;
  int net, errors = 0, checks = 0, cyc = 0;
  logic [31:0] spds [3] = '{32'h0000_7530, 32'hFFFF_8AD0, 32'h0000_7530};
  logic sns [3] = '{1'b0, 1'b0, 1'b1};

  smp_profile_gen #(.TICK_CYC(100)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pos_clear_evt(pos_clear_evt), .pos_restore(pos_restore),
    .pos_restore_val(pos_restore_val), .pos_backup(pos_backup), .step_out(step_out),
    .dir_out(dir_out), .nv_req(nv_req), .nv_addr(nv_addr), .nv_data(nv_data));
  smp_stage_model u_stage (.aclk(aclk), .step_out(step_out), .dir_out(dir_out),
    .sense(sense), .net(net));

  // ----------------------------------------------------------------
  // clock, timeout, verdict
  // ----------------------------------------------------------------
  always #5 aclk = ~aclk;
  // cut a hang short
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      errors = errors + 1;
      results();
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ----------------------------------------------------------------
  // bus tasks: hold each channel until its ready
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'h0, {30'h0, bresp});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  // speed from the status word must lie in [lo, hi]
  task automatic speed_cmd(input int w, input logic [15:0] lo, input logic [15:0] hi);
    repeat (w) @(posedge aclk);
    rd(smp_pkg::OFS_STAT, v, rs);
    chk("speed window", 32'h1, {31'h0, (v[31:16] >= lo && v[31:16] <= hi)});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // the eleven registers below the status word reset to zero, unmapped gives an error
    for (int i = 0; i < 11; i++)
    begin
      rd(8'(i * 4), v, rs);
      chk("reset word", smp_pkg::RST_WORD, v);
    end
    // zero speed counts as forward, and the direction follows at once
    rd(smp_pkg::OFS_STAT, v, rs);
    chk("status after reset", 32'h1, v);
    rd(8'h40, v, rs);
    chk("unmapped resp", {30'h0, smp_pkg::RESP_SLVERR}, {30'h0, rs});
    wr(smp_pkg::OFS_BLC, 32'h0001_1170);
    chk("save offset", {24'h0, smp_pkg::OFS_BLC}, {24'h0, nv_addr});
    rd(smp_pkg::OFS_BLC, v, rs);
    chk("backlash clip", smp_pkg::BLC_MAX, v);
    wr(smp_pkg::OFS_BLC, 32'h0);
    // position follows steps, direction follows speed sign
    for (int i = 0; i < 3; i++)
    begin
      wr(smp_pkg::OFS_INPUT_CONFIG_REG, {31'h0, sns[i]});
      sense <= sns[i];
      wr(smp_pkg::OFS_SPEED, spds[i]);
      repeat (15000) @(posedge aclk);
      chk("direction", {31'h0, ~spds[i][15]}, {31'h0, dir_out});
      wr(smp_pkg::OFS_SPEED, 32'h0);
      repeat (10) @(posedge aclk);
      rd(smp_pkg::OFS_POS, v, rs);
      chk("position", 32'(net), v);
    end
    // position restore, host clear and sensor clear
    pos_restore_val <= 32'h0000_1234;
    pos_restore <= 1'b1;
    @(posedge aclk);
    pos_restore <= 1'b0;
    rd(smp_pkg::OFS_POS, v, rs);
    chk("restored", 32'h0000_1234, v);
    wr(smp_pkg::OFS_POS, 32'h0);
    rd(smp_pkg::OFS_POS, v, rs);
    chk("host clear", 32'h0, v);
    pos_restore <= 1'b1;
    @(posedge aclk);
    pos_restore <= 1'b0;
    pos_clear_evt <= 1'b1;
    @(posedge aclk);
    pos_clear_evt <= 1'b0;
    rd(smp_pkg::OFS_POS, v, rs);
    chk("event clear", 32'h0, v);
    // ramps: 1000 pps per tick, zero start/stop speeds first
    wr(smp_pkg::OFS_MASTER_CONFIG_REG, 32'h0000_0400);
    wr(smp_pkg::OFS_ACCEL, 32'h000F_4240);
    wr(smp_pkg::OFS_DECEL, 32'h000F_4240);
    wr(smp_pkg::OFS_SPEED, 32'h0000_1388);
    speed_cmd(250, 16'd1, 16'd4999);
    speed_cmd(600, 16'd5000, 16'd5000);
    wr(smp_pkg::OFS_SPEED, 32'h0);
    speed_cmd(250, 16'd1, 16'd4999);
    speed_cmd(600, 16'd0, 16'd0);
    wr(smp_pkg::OFS_MSS, 32'h0000_1F40);
    wr(smp_pkg::OFS_MSD, 32'h0000_1F40);
    wr(smp_pkg::OFS_SPEED, 32'h0000_1388);
    speed_cmd(150, 16'd5000, 16'd5000);
    wr(smp_pkg::OFS_SPEED, 32'h0);
    speed_cmd(150, 16'd0, 16'd0);
    wr(smp_pkg::OFS_MSS, 32'h0000_0BB8);
    wr(smp_pkg::OFS_MSD, 32'h0000_0BB8);
    wr(smp_pkg::OFS_SPEED, 32'h0000_1F40);
    speed_cmd(150, 16'd3000, 16'd7999);
    speed_cmd(700, 16'd8000, 16'd8000);
    wr(smp_pkg::OFS_SPEED, 32'h0000_2EE0);
    speed_cmd(150, 16'd8001, 16'd11999);
    speed_cmd(500, 16'd12000, 16'd12000);
    wr(smp_pkg::OFS_SPEED, 32'h0000_03E8);
    speed_cmd(150, 16'd3001, 16'd11999);
    speed_cmd(1200, 16'd1000, 16'd1000);
    // period mode: 10 ticks from 1000 to 3000 pps, no start jump
    wr(smp_pkg::OFS_MSS, 32'h0);
    wr(smp_pkg::OFS_MASTER_CONFIG_REG, 32'h0000_0C00);
    wr(smp_pkg::OFS_ACCEL, 32'h0000_000A);
    wr(smp_pkg::OFS_SPEED, 32'h0000_0BB8);
    speed_cmd(550, 16'd1001, 16'd2999);
    speed_cmd(700, 16'd3000, 16'd3000);
    // reversal waits for standstill; rate mode, plain ramps both ways
    wr(smp_pkg::OFS_MASTER_CONFIG_REG, 32'h0000_0400);
    wr(smp_pkg::OFS_ACCEL, 32'h000F_4240);
    wr(smp_pkg::OFS_MSD, 32'h0);
    wr(smp_pkg::OFS_SPEED, 32'hFFFF_F448);
    repeat (50) @(posedge aclk);
    chk("no instant turn", 32'h1, {31'h0, dir_out});
    speed_cmd(4000, 16'd3000, 16'd3000);
    chk("turned", 32'h0, {31'h0, dir_out});
    results();
  end
endmodule
